/* src/drive_if.sv */
/*
  Carrier between the sequencer core and its phase output stage.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/100ps
interface drive_if;
  logic [2:0] pos;
  logic drive_on;
  logic [3:0] phases;
  modport seq (output pos, output drive_on, input phases);
  modport drv (input pos, input drive_on, output phases);
endinterface

/* src/phase_driver.sv */
/*
  Phase output stage: registers the coil pattern of the current position.
  Assumes the sequencer drives position and the drive gate from its own flip-flops.
*/
`timescale 1ns/100ps
module phase_driver
  import stepper_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the sequencer.
  drive_if.drv dif
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0] phases;
  } drv_state_s;

  drv_state_s st_q;
  drv_state_s st_d;

  // Gated pattern; off whenever the drive gate is low.
  always_comb begin
    st_d = st_q;
    st_d.phases = dif.drive_on ? phase_pattern(dif.pos) : PHASES_OFF;
  end

  // Register the outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dif.phases = st_q.phases;

endmodule

/* src/stepper_phase_sequencer.sv */
/*
  Stepper phase sequencer top: pin synchronisers, step edge qualifier, phase position,
  fault latch and AXI4-Lite register slave.
  Assumes host pins are asynchronous to aclk and the host keeps direction stable
  around step edges and waits after reset release before stepping.
*/
// Function
// - Excitation select low chooses full-step two-phase, high chooses half-step.
// - Edge select high steps on rising edges only, low steps on both edges.
// - Each qualifying step edge moves the phase pattern by exactly one step.
// - Direction low steps forward, high steps in reverse order.
// - While the reset pin is low the sequencing logic stays in its reset state.
// - On reset release the sequence starts at the position with A and B-bar on.
// - While enable is low all four phase outputs are off.
// - When enable returns high driving resumes from the held position.
// - The open-drain fault output is pulled low while a fault is latched.
// - A fault latches and turns outputs off until power-on or pin reset clears it.
// - While enable is low step edges change neither the position nor the step count.
`timescale 1ns/100ps
module stepper_phase_sequencer
  import stepper_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host control pins.
  input wire logic step_clock,
  input wire logic rotation_direction,
  input wire logic excitation_select,
  input wire logic edge_select,
  input wire logic enable,
  input wire logic reset_n_input,
  // Detector inputs.
  input wire logic overcurrent_detect,
  input wire logic overheat_detect,
  // Phase drive outputs.
  output logic phase_a,
  output logic phase_a_bar,
  output logic phase_b,
  output logic phase_b_bar,
  // Open-drain fault pin.
  output logic fault_n_out,
  output logic fault_oe
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic step_prev;
    logic [2:0] pos;
    logic oc_lat;
    logic ot_lat;
    logic sw_en;
    logic [STEPS_W-1:0] steps;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_state_s;

  seq_state_s st_q;
  seq_state_s st_d;

  drive_if dif ();

  logic [IN_W-1:0] pins;
  logic rst_ok;
  logic run;
  logic fault_any;
  logic rise_raw;
  logic fall_raw;
  logic qual;
  logic half;
  logic ccw;
  logic do_write;

  // ==========================================================================
  // Step qualification
  // ==========================================================================
  // Raw pin vector into the synchroniser, and pin levels decoded from its second stage.
  assign pins = {overheat_detect, overcurrent_detect, reset_n_input, enable,
                 edge_select, excitation_select, rotation_direction, step_clock};
  assign rst_ok = st_q.sync2[IN_RST];
  assign run = st_q.sync2[IN_EN] && st_q.sw_en;
  assign fault_any = st_q.oc_lat || st_q.ot_lat;
  assign half = st_q.sync2[IN_EXC];
  assign ccw = st_q.sync2[IN_DIR];
  assign rise_raw = st_q.sync2[IN_STEP] && !st_q.step_prev;
  assign fall_raw = !st_q.sync2[IN_STEP] && st_q.step_prev;
  assign qual = run && (rise_raw || (fall_raw && !st_q.sync2[IN_EDGE]));
  assign do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;

  // Read data of one register address.
  function automatic logic [31:0] read_word(input seq_state_s s, input logic [ADDR_W-1:0] a,
                                            input logic r, input logic f);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ADDR_CTRL) begin
      v[CTRL_EN_BIT] = s.sw_en;
    end else if (a == ADDR_STATUS) begin
      v[STAT_POS_LSB +: 3] = s.pos;
      v[STAT_FAULT_BIT] = f;
      v[STAT_OC_BIT] = s.oc_lat;
      v[STAT_OT_BIT] = s.ot_lat;
      v[STAT_RUN_BIT] = r;
      v[STAT_HALF_BIT] = s.sync2[IN_EXC];
    end else if (a == ADDR_STEPS) begin
      v[STEPS_W-1:0] = s.steps;
    end
    return v;
  endfunction

  // Address decode shared by both channels.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_STEPS);
  endfunction

  // Next state of the sequencer, fault latch and bus slave.
  always_comb begin
    st_d = st_q;
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    // Step level tracks always so a re-enable never sees a stale edge.
    st_d.step_prev = st_q.sync2[IN_STEP];
    if (!rst_ok) begin
      st_d.pos = POS_INIT;
    end else if (qual) begin
      st_d.pos = next_pos(st_q.pos, half, ccw);
    end
    // Fault latch: pin reset clears, a detection in the same cycle wins.
    if (!rst_ok) begin
      st_d.oc_lat = 1'b0;
      st_d.ot_lat = 1'b0;
    end
    if (st_q.sync2[IN_OC]) begin
      st_d.oc_lat = 1'b1;
    end
    if (st_q.sync2[IN_OT]) begin
      st_d.ot_lat = 1'b1;
    end
    // Write channel: take address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if ((st_q.aw_addr == ADDR_CTRL) && st_q.w_strb[0]) begin
        st_d.sw_en = st_q.w_data[CTRL_EN_BIT];
      end
    end
    // Step counter: a write clears, a step in the same cycle still counts.
    if (do_write && (st_q.aw_addr == ADDR_STEPS)) begin
      st_d.steps = STEPS_RESET;
    end
    if (qual && rst_ok) begin
      st_d.steps = STEPS_W'(st_d.steps + 1'b1);
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Read channel: one word answered the cycle after the address.
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = read_word(st_q, s_axi_araddr, run, fault_any);
      st_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  // Register the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.sw_en <= CTRL_EN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Drive gate: enabled, no latched fault.
  assign dif.pos = st_q.pos;
  assign dif.drive_on = run && !fault_any;

  phase_driver u_drv (
    .aclk (aclk),
    .aresetn (aresetn),
    .dif (dif)
  );

  // Phase pins and open-drain fault pin.
  assign {phase_a, phase_a_bar, phase_b, phase_b_bar} = dif.phases;
  assign fault_n_out = 1'b0;
  assign fault_oe = fault_any;

  // Bus handshakes and answers.
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_release;
    !rst_ok ##1 rst_ok;
  endsequence

  sequence s_resume;
    !run ##1 (run && !fault_any && rst_ok);
  endsequence

  property p_half_fwd;
    @(posedge aclk) disable iff (!aresetn)
      (qual && rst_ok && half && !ccw) |=> (st_q.pos == 3'($past(st_q.pos) + 3'h1));
  endproperty
  a_half_fwd: assert property (p_half_fwd) else $error("half-step forward wrong");

  property p_full_two_phase;
    @(posedge aclk) disable iff (!aresetn)
      (qual && rst_ok && !half && !st_q.pos[0]) |=> (!st_q.pos[0] && st_q.pos != $past(st_q.pos));
  endproperty
  a_full_two_phase: assert property (p_full_two_phase) else $error("full-step left two-phase");

  property p_rise_only;
    @(posedge aclk) disable iff (!aresetn)
      (fall_raw && st_q.sync2[IN_EDGE] && rst_ok) |=> $stable(st_q.pos);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("falling edge stepped");

  property p_one_step;
    @(posedge aclk) disable iff (!aresetn)
      (qual && rst_ok) |=> (st_q.pos == next_pos($past(st_q.pos), $past(half), $past(ccw)));
  endproperty
  a_one_step: assert property (p_one_step) else $error("step not exactly one");

  property p_reverse;
    @(posedge aclk) disable iff (!aresetn)
      (qual && rst_ok && half && ccw) |=> (st_q.pos == 3'($past(st_q.pos) - 3'h1));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse order wrong");

  property p_reset_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!rst_ok ##1 !rst_ok) |-> (st_q.pos == POS_INIT) &&
        ((st_q.steps == $past(st_q.steps)) || $past(do_write));
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("sequencer moved in reset");

  property p_release;
    @(posedge aclk) disable iff (!aresetn)
      (s_release ##0 dif.drive_on) |-> (st_q.pos == POS_INIT) ##1
        (dif.phases == phase_pattern(POS_INIT));
  endproperty
  a_release: assert property (p_release) else $error("start state not A and B-bar");

  property p_enable_off;
    @(posedge aclk) disable iff (!aresetn)
      !run |=> (dif.phases == PHASES_OFF);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("phases on while disabled");

  property p_resume;
    @(posedge aclk) disable iff (!aresetn)
      s_resume |=> (dif.phases == phase_pattern($past(st_q.pos)));
  endproperty
  a_resume: assert property (p_resume) else $error("resume lost position");

  property p_fault_pin;
    @(posedge aclk) disable iff (!aresetn)
      (st_q.sync2[IN_OC] || st_q.sync2[IN_OT]) |=> (fault_oe && !fault_n_out) [*2];
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

  property p_fault_latch;
    @(posedge aclk) disable iff (!aresetn)
      (fault_any && rst_ok) |=> fault_any && (dif.phases == PHASES_OFF);
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched off");

  property p_frozen;
    @(posedge aclk) disable iff (!aresetn)
      (!run && rst_ok) |=> $stable(st_q.pos) && $stable(st_q.steps);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state changed while disabled");

endmodule

/* src/stepper_pkg.sv */
/*
  Shared constants, register map and phase functions of the stepper phase sequencer.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package stepper_pkg;

  // ==========================================================================
  // Clock and host timing
  // ==========================================================================
  localparam int CLK_FREQ_MHZ = 100;
  // Direction stable window around every step edge, held by the host.
  localparam int DIR_HOLD_NS = 6250;
  localparam int DIR_HOLD_CYC = (DIR_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
  // Least wait from reset release to the first step edge, kept by the host.
  localparam int RESET_TO_STEP_NS = 10000;
  localparam int RESET_TO_STEP_CYC = (RESET_TO_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STEPS = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_OC_BIT = 4;
  localparam int STAT_OT_BIT = 5;
  localparam int STAT_RUN_BIT = 6;
  localparam int STAT_HALF_BIT = 7;
  localparam int STEPS_W = 16;
  localparam logic [STEPS_W-1:0] STEPS_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Input pin slots of the synchroniser vector
  // ==========================================================================
  localparam int IN_W = 8;
  localparam int IN_STEP = 0;
  localparam int IN_DIR = 1;
  localparam int IN_EXC = 2;
  localparam int IN_EDGE = 3;
  localparam int IN_EN = 4;
  localparam int IN_RST = 5;
  localparam int IN_OC = 6;
  localparam int IN_OT = 7;
  localparam logic [IN_W-1:0] SYNC_RESET = 8'h00;

  // ==========================================================================
  // Phase position
  // ==========================================================================
  localparam logic [2:0] POS_INIT = 3'h0;
  localparam logic [3:0] PHASES_OFF = 4'h0;

  // Phase pattern {a, a_bar, b, b_bar} for each half-step position.
  function automatic logic [3:0] phase_pattern(input logic [2:0] pos);
    logic [3:0] p;
    p = PHASES_OFF;
    unique case (pos)
      3'h0: p = 4'h9;
      3'h1: p = 4'h8;
      3'h2: p = 4'ha;
      3'h3: p = 4'h2;
      3'h4: p = 4'h6;
      3'h5: p = 4'h4;
      3'h6: p = 4'h5;
      3'h7: p = 4'h1;
    endcase
    return p;
  endfunction

  // Next position; full-step lands on and keeps to the two-phase positions.
  function automatic logic [2:0] next_pos(input logic [2:0] pos, input logic half,
                                          input logic ccw);
    logic [2:0] inc;
    inc = (half || pos[0]) ? 3'h1 : 3'h2;
    return ccw ? 3'(pos - inc) : 3'(pos + inc);
  endfunction

endpackage

/* tb/host_model.sv */
/*
  Host controller model: drives the step, direction, mode, enable and reset pins.
  Assumes one bench process calls its tasks right after a rising edge of aclk.
*/
`timescale 1ns/100ps
module host_model
  import stepper_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Control pins.
  output logic step_clock,
  output logic rotation_direction,
  output logic excitation_select,
  output logic edge_select,
  output logic enable,
  output logic reset_n_input
);
  // ==========================================================================
  // Pin tasks
  // ==========================================================================
  // Pins start idle with the sequencer held in reset.
  initial begin
    step_clock = 1'b0;
    rotation_direction = 1'b0;
    excitation_select = 1'b0;
    edge_select = 1'b1;
    enable = 1'b1;
    reset_n_input = 1'b0;
  end

  // One step edge; direction is held steady on both sides of it.
  task automatic step_edge(input logic lvl, input logic dir);
    @(posedge aclk);
    rotation_direction <= dir;
    repeat (DIR_HOLD_CYC) @(posedge aclk);
    step_clock <= lvl;
    repeat (DIR_HOLD_CYC) @(posedge aclk);
  endtask

  // Level pins; a reset release is followed by the quiet time before stepping.
  task automatic set_pins(input logic x, input logic g, input logic e, input logic rs);
    @(posedge aclk);
    excitation_select <= x;
    edge_select <= g;
    enable <= e;
    reset_n_input <= rs;
    if (rs && !reset_n_input) begin
      repeat (RESET_TO_STEP_CYC) @(posedge aclk);
    end else begin
      repeat (8) @(posedge aclk);
    end
  endtask
endmodule

/* tb/test_stepper_phase_sequencer.sv */
/*
  Self-checking bench of the stepper phase sequencer against a queue-free integer model.
  Assumes the host model drives the pins and this bench drives AXI4-Lite and detectors.
*/
`timescale 1ns/100ps
module test_stepper_phase_sequencer
  import stepper_pkg::*;
();
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, step_clock, rotation_direction;
  logic excitation_select, edge_select, enable, reset_n_input, fault_n_out, fault_oe;
  logic overcurrent_detect, overheat_detect, phase_a, phase_a_bar, phase_b, phase_b_bar;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [3:0] pat [8];
  logic [1:0] bresp, rresp, r;
  logic [2:0] rv;
  logic exc, edg, en, sw, rstn, lvl, oc, ot;
  int fails, num_checks, pos, cnt;

  // The 100 MHz clock.
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  stepper_phase_sequencer stepper_phase_sequencer_i (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_clock, .rotation_direction, .excitation_select, .edge_select, .enable,
    .reset_n_input, .overcurrent_detect, .overheat_detect, .phase_a, .phase_a_bar,
    .phase_b, .phase_b_bar, .fault_n_out, .fault_oe);

  host_model host_model_i (.aclk, .step_clock, .rotation_direction, .excitation_select,
    .edge_select, .enable, .reset_n_input);

  // ==========================================================================
  // Checks and bus cycles
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Coil pattern and the fault wire, which a pull-up holds high when released.
  task automatic chk_pins;
    // Look mid-cycle so a pattern launched at the last edge is already settled.
    @(negedge aclk);
    chk("phases", (en && sw && !(oc || ot)) ? pat[pos] : 4'h0,
        {phase_a, phase_a_bar, phase_b, phase_b_bar});
    chk("fault_wire", !(oc || ot), fault_oe ? fault_n_out : 1'b1);
  endtask

  // One AXI4-Lite write or read; handshakes are sampled at the falling edge before.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dd);
    logic aw_t, w_t, ar_t, done;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    if (wr) begin
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && n < 100) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      ar_t = arvalid && arready;
      done = wr ? bvalid : rvalid;
      d = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (ar_t) arvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
      n++;
    end
    chk("bus_answer", 32'h1, 32'(done));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    chk("rdata", e, d & m);
    chk("rresp", er, r);
  endtask

  function automatic logic [31:0] st();
    return {24'h0, exc, en && sw, ot, oc, oc || ot, 3'(pos)};
  endfunction

  // One edge of the step pin; the model steps when the edge qualifies.
  task automatic step(input logic l, input logic dir);
    int inc;
    inc = (exc || (pos & 1)) ? 1 : 2;
    host_model_i.step_edge(l, dir);
    if (rstn && en && sw && (l != lvl) && (l || !edg)) begin
      cnt++;
      pos = (pos + (dir ? 8 - inc : inc)) & 7;
    end
    lvl = l;
    chk_pins;
  endtask

  task automatic pins(input logic x, input logic g, input logic e, input logic rs);
    host_model_i.set_pins(x, g, e, rs);
    exc = x;
    edg = g;
    en = e;
    rstn = rs;
    if (!rs) begin
      pos = 0;
      oc = 1'b0;
      ot = 1'b0;
    end
    chk_pins;
  endtask

  task automatic stop_test;
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Cuts a hang short.
  initial begin
    repeat (80000) @(posedge aclk);
    fails++;
    stop_test;
  end

  // Main sequence.
  initial begin
    {fails, num_checks, pos, cnt} = '0;
    {exc, en, sw, rstn, lvl, oc, ot} = '0;
    {edg, en, sw} = 3'h7;
    pat = '{4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {overcurrent_detect, overheat_detect} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h53663add));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    rd_chk(ADDR_CTRL, 32'h1, 32'h1, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'hff, st(), RESP_OKAY);
    rd_chk(ADDR_STEPS, 32'hffff, 32'h0, RESP_OKAY);
    // Random modes, edges and directions.
    repeat (24) begin
      rv = 3'($urandom);
      pins(rv[0], rv[1], 1'b1, 1'b1);
      step(~lvl, rv[2]);
    end
    rd_chk(ADDR_STATUS, 32'hff, st(), RESP_OKAY);
    rd_chk(ADDR_STEPS, 32'hffff, cnt, RESP_OKAY);
    bus(1'b1, ADDR_STEPS, 32'h0);
    cnt = 0;
    rd_chk(ADDR_STEPS, 32'hffff, 32'h0, RESP_OKAY);
    // Enable low drops the coils and ignores edges; re-enable resumes in place.
    pins(exc, 1'b0, 1'b0, 1'b1);
    step(~lvl, 1'b0);
    step(~lvl, 1'b1);
    pins(exc, 1'b0, 1'b1, 1'b1);
    // Software enable and an unmapped place.
    bus(1'b1, ADDR_CTRL, 32'h0);
    sw = 1'b0;
    chk_pins;
    bus(1'b1, ADDR_CTRL, 32'h1);
    sw = 1'b1;
    chk_pins;
    bus(1'b1, 8'h0c, 32'h1);
    chk("bresp", RESP_SLVERR, r);
    rd_chk(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
    // Each detector latches until a reset pin pulse clears it.
    for (int i = 0; i < 2; i++) begin
      step(~lvl, 1'b0);
      @(posedge aclk);
      overcurrent_detect <= (i == 0);
      overheat_detect <= (i == 1);
      repeat (8) @(posedge aclk);
      overcurrent_detect <= 1'b0;
      overheat_detect <= 1'b0;
      repeat (8) @(posedge aclk);
      oc = (i == 0);
      ot = (i == 1);
      chk_pins;
      rd_chk(ADDR_STATUS, 32'hff, st(), RESP_OKAY);
      pins(exc, edg, 1'b1, 1'b0);
      step(~lvl, 1'b1);
      pins(exc, edg, 1'b1, 1'b1);
    end
    stop_test;
  end
endmodule
